// ---- swm_crc16.v ----
// CRC16 generator, one byte per enabled cycle, LSB first.
// Assumes clear and load are one-cycle pulses from the sequencer; enable stays high one cycle per byte.
`include "swm_regs.vh"

module swm_crc16 (
  input  wire        clock_in,
  input  wire        reset_in,
  input  wire        clr_in,
  input  wire        load_in,
  input  wire [15:0] load_val_in,
  input  wire        en_in,
  input  wire [7:0]  byte_in,
  output reg  [15:0] crc_out
);

  function [15:0] crc_step;
    input [15:0] c;
    input [7:0]  d;
    integer      i;
    reg   [15:0] r;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (r[0] ^ d[i]) begin
          r = (r >> 1) ^ `SWM_CRC_POLY;
        end else begin
          r = r >> 1;
        end
      end
      crc_step = r;
    end
  endfunction

  always @(posedge clock_in) begin
    if (reset_in || clr_in) begin
      crc_out <= 16'h0000;
    end else if (load_in) begin
      crc_out <= load_val_in;
    end else if (en_in) begin
      crc_out <= crc_step(crc_out, byte_in);
    end
  end

endmodule

// ---- swm_dev_model.sv ----
// Behavioural slave on the single-wire line with status memory and CRC16.
// Assumes the bench resolves the wired-AND line with a pull-up.
module swm_dev_model #(
  parameter logic [63:0] ID = 64'h0
) (
  input  wire  line_in,
  input  wire  prog_in,
  output logic pull_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       od = 1'b0;
  logic [7:0] mem [512];
  realtime    t0;
  initial begin
    pull_n_out = 1'b1;
    foreach (mem[j]) mem[j] = 8'hFF;
  end
  function automatic logic [15:0] cu(logic [15:0] c, logic [7:0] d);
    for (int j = 0; j < 8; j++)
      c = (c[0] ^ d[j]) ? (c >> 1) ^ 16'hA001 : c >> 1;
    return c;
  endfunction
  task automatic sl(input logic b, output logic r);
    @(negedge line_in);
    pull_n_out = b;
    #(od ? 3000 : 30000);
    r = line_in;
    pull_n_out = 1'b1;
  endtask
  task automatic rx(output logic [7:0] v);
    for (int i = 0; i < 8; i++) sl(1'b1, v[i]);
  endtask
  task automatic run();
    logic [7:0]  c, d, v;
    logic [15:0] a, k;
    logic        r;
    #(od ? 2000 : 15000);
    pull_n_out = 1'b0;
    #(od ? 10000 : 60000);
    pull_n_out = 1'b1;
    rx(c);
    if (!(c inside {8'h33, 8'h55, 8'h69, 8'hCC, 8'h3C, 8'hF0})) return;
    if (c == 8'h3C || c == 8'h69) od = 1'b1;
    if (c == 8'h33) for (int i = 0; i < 64; i++) sl(ID[i], r);
    if (c == 8'h55 || c == 8'h69) for (int i = 0; i < 64; i++) begin
      sl(1'b1, r);
      if (r !== ID[i]) return;
    end
    if (c == 8'hF0) for (int i = 0; i < 192; i++) begin
      sl(i % 3 == 2 || ID[i / 3] ^ (i % 3 == 1), r);
      if (i % 3 == 2 && r !== ID[i / 3]) return;
    end
    rx(c);
    if (c != 8'h55 && c != 8'hF5) return;
    rx(a[7:0]);
    rx(a[15:8]);
    a[15:13] = 3'h0;
    k = cu(cu(cu(16'h0, c), a[7:0]), a[15:8]);
    forever begin
      rx(d);
      k = cu(k, d);
      if (c == 8'h55) for (int i = 0; i < 16; i++) sl(~k[i], r);
      @(posedge prog_in);
      @(negedge prog_in);
      if (a <= 16'h01FF) mem[a[8:0]] &= d;
      v = a <= 16'h01FF ? mem[a[8:0]] : 8'hFF;
      for (int i = 0; i < 8; i++) sl(v[i], r);
      a++;
      k = a;
    end
  endtask
  always @(negedge line_in) begin
    t0 = $realtime;
    @(posedge line_in);
    if ($realtime - t0 > 64000) begin
      if ($realtime - t0 >= 80000) od = 1'b0;
      disable tr;
      pull_n_out = 1'b1;
      fork
        begin : tr
          run();
        end
      join_none
    end
  end
endmodule

// ---- swm_master.v ----
// Bus master for a single-wire add-only memory: identity phase and
// status-memory byte writes. Assumes a pull-up on the line, an external
// 12 V switch driven by prog_en_out, and a user that supplies bytes.
`include "swm_regs.vh"

module swm_master #(
  parameter [19:0] RST_CYC  = `SWM_REG_RSTL_CYC,
  parameter [19:0] RREC_CYC = `SWM_REG_RREC_CYC,
  parameter [19:0] PROG_CYC = `SWM_PROG_CYC
) (
  input  wire        clock_in,
  input  wire        reset_in,
  input  wire        cmd_valid_in,
  output reg         cmd_ready_out,
  input  wire [2:0]  rom_op_in,
  input  wire        long_reset_in,
  input  wire [63:0] rom_id_in,
  input  wire        write_in,
  input  wire        speed_write_in,
  input  wire [15:0] addr_in,
  input  wire [7:0]  data_in,
  input  wire        last_in,
  input  wire        byte_valid_in,
  output reg         byte_ready_out,
  input  wire        line_in,
  output wire        line_oe_n_out,
  output wire        prog_en_out,
  output reg         done_out,
  output reg         error_out,
  output reg  [1:0]  err_code_out,
  output reg         presence_out,
  output reg         crc_ok_out,
  output reg  [7:0]  verify_byte_out,
  output reg  [15:0] addr_out,
  output reg  [63:0] rom_out,
  output reg         overdrive_flag_out
);

  localparam [15:0] S_IDLE   = 16'h0001;
  localparam [15:0] S_RST    = 16'h0002;
  localparam [15:0] S_TX     = 16'h0004;
  localparam [15:0] S_RX     = 16'h0008;
  localparam [15:0] S_ROMD   = 16'h0010;
  localparam [15:0] S_ROMEND = 16'h0020;
  localparam [15:0] S_SRA    = 16'h0040;
  localparam [15:0] S_SRB    = 16'h0080;
  localparam [15:0] S_SRW    = 16'h0100;
  localparam [15:0] S_CALC   = 16'h0200;
  localparam [15:0] S_CRCCHK = 16'h0400;
  localparam [15:0] S_PROG   = 16'h0800;
  localparam [15:0] S_VER    = 16'h1000;
  localparam [15:0] S_NEXT   = 16'h2000;
  localparam [15:0] S_FAIL   = 16'h4000;
  localparam [15:0] S_DONE   = 16'h8000;

  reg [15:0] state_q;
  reg [15:0] ret_q;
  reg [63:0] sh_q;
  reg [6:0]  n_q;
  reg        wait_q;
  reg        go_q;
  reg [1:0]  sop_q;
  reg        sbit_q;
  reg        sod_q;
  reg [2:0]  rop_q;
  reg [63:0] id_q;
  reg        wr_q;
  reg        spd_q;
  reg        long_q;
  reg        last_q;
  reg [7:0]  data_q;
  reg [5:0]  idx_q;
  reg        a_q;
  reg        dir_q;
  reg [31:0] feed_q;
  reg [1:0]  k_q;
  reg        crc_clr_q;
  reg        crc_ld_q;
  reg        crc_en_q;
  reg [7:0]  crc_byte_q;

  wire        slot_done;
  wire        slot_bit;
  wire [15:0] crc_val;
  wire        fin = wait_q && slot_done;

  function [7:0] rom_code;
    input [2:0] op;
    begin
      case (op)
        `SWM_ROP_MATCH:    rom_code = `SWM_CMD_MATCH_ID;
        `SWM_ROP_READ:     rom_code = `SWM_CMD_READ_ID;
        `SWM_ROP_SEARCH:   rom_code = `SWM_CMD_SEARCH_ID;
        `SWM_ROP_OD_SKIP:  rom_code = `SWM_CMD_OD_SKIP;
        `SWM_ROP_OD_MATCH: rom_code = `SWM_CMD_OD_MATCH;
        default:           rom_code = `SWM_CMD_SKIP_ID;
      endcase
    end
  endfunction

  // Starts one slot unless one is already pending
  task issue;
    input [1:0] op;
    input       b;
    begin
      if (!wait_q) begin
        go_q   <= 1'b1;
        wait_q <= 1'b1;
        sop_q  <= op;
        sbit_q <= b;
        sod_q  <= overdrive_flag_out &
                  ~((op == `SWM_OP_RST) && long_q);
      end
    end
  endtask

  swm_slot #(
    .RST_CYC  (RST_CYC),
    .RREC_CYC (RREC_CYC),
    .PROG_CYC (PROG_CYC)
  ) u_slot (
    .clock_in      (clock_in),
    .reset_in      (reset_in),
    .go_in         (go_q),
    .op_in         (sop_q),
    .bit_in        (sbit_q),
    .od_in         (sod_q),
    .line_in       (line_in),
    .done_out      (slot_done),
    .bit_out       (slot_bit),
    .line_oe_n_out (line_oe_n_out),
    .prog_en_out   (prog_en_out)
  );

  swm_crc16 u_crc (
    .clock_in    (clock_in),
    .reset_in    (reset_in),
    .clr_in      (crc_clr_q),
    .load_in     (crc_ld_q),
    .load_val_in (addr_out),
    .en_in       (crc_en_q),
    .byte_in     (crc_byte_q),
    .crc_out     (crc_val)
  );

  always @(posedge clock_in) begin
    if (reset_in) begin
      state_q <= S_IDLE;
      ret_q <= S_IDLE;
      sh_q <= 64'h0;
      n_q <= 7'h00;
      wait_q <= 1'b0;
      go_q <= 1'b0;
      sop_q <= `SWM_OP_RST;
      sbit_q <= 1'b0;
      sod_q <= 1'b0;
      rop_q <= `SWM_ROP_SKIP;
      id_q <= 64'h0;
      wr_q <= 1'b0;
      spd_q <= 1'b0;
      long_q <= 1'b0;
      last_q <= 1'b0;
      data_q <= 8'h00;
      idx_q <= 6'h00;
      a_q <= 1'b0;
      dir_q <= 1'b0;
      feed_q <= 32'h0;
      k_q <= 2'h0;
      crc_clr_q <= 1'b0;
      crc_ld_q <= 1'b0;
      crc_en_q <= 1'b0;
      crc_byte_q <= 8'h00;
      cmd_ready_out <= 1'b0;
      byte_ready_out <= 1'b0;
      done_out <= 1'b0;
      error_out <= 1'b0;
      err_code_out <= `SWM_ERR_NONE;
      presence_out <= 1'b0;
      crc_ok_out <= 1'b0;
      verify_byte_out <= 8'h00;
      addr_out <= 16'h0000;
      rom_out <= 64'h0;
      overdrive_flag_out <= 1'b0;
    end else begin
      go_q <= 1'b0;
      done_out <= 1'b0;
      crc_clr_q <= 1'b0;
      crc_ld_q <= 1'b0;
      crc_en_q <= 1'b0;
      if (fin) begin
        wait_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          cmd_ready_out <= 1'b1;
          if (cmd_valid_in && cmd_ready_out) begin
            cmd_ready_out <= 1'b0;
            rop_q <= rom_op_in;
            id_q <= rom_id_in;
            wr_q <= write_in;
            spd_q <= speed_write_in;
            long_q <= long_reset_in;
            addr_out <= addr_in;
            data_q <= data_in;
            last_q <= last_in;
            error_out <= 1'b0;
            err_code_out <= `SWM_ERR_NONE;
            crc_ok_out <= 1'b0;
            state_q <= S_RST;
          end
        end
        S_RST: begin
          issue(`SWM_OP_RST, 1'b0);
          if (fin) begin
            if (long_q) begin
              overdrive_flag_out <= 1'b0;
            end
            presence_out <= slot_bit;
            if (!slot_bit) begin
              err_code_out <= `SWM_ERR_NOPRES;
              state_q <= S_DONE;
            end else begin
              sh_q <= {56'h0, rom_code(rop_q)};
              n_q <= 7'd8;
              ret_q <= S_ROMD;
              state_q <= S_TX;
            end
          end
        end
        S_TX: begin
          issue(`SWM_OP_WR, sh_q[0]);
          if (fin) begin
            sh_q <= {1'b0, sh_q[63:1]};
            n_q <= n_q - 7'd1;
            if (n_q == 7'd1) begin
              state_q <= ret_q;
            end
          end
        end
        S_RX: begin
          issue(`SWM_OP_RD, 1'b1);
          if (fin) begin
            sh_q <= {slot_bit, sh_q[63:1]};
            n_q <= n_q - 7'd1;
            if (n_q == 7'd1) begin
              state_q <= ret_q;
            end
          end
        end
        S_ROMD: begin
          if (rop_q == `SWM_ROP_OD_SKIP || rop_q == `SWM_ROP_OD_MATCH) begin
            overdrive_flag_out <= 1'b1;
          end
          ret_q <= S_ROMEND;
          idx_q <= 6'h00;
          n_q <= 7'd64;
          sh_q <= id_q;
          case (rop_q)
            `SWM_ROP_MATCH, `SWM_ROP_OD_MATCH: state_q <= S_TX;
            `SWM_ROP_READ:   state_q <= S_RX;
            `SWM_ROP_SEARCH: state_q <= S_SRA;
            default:         state_q <= S_ROMEND;
          endcase
        end
        S_SRA: begin
          issue(`SWM_OP_RD, 1'b1);
          if (fin) begin
            a_q <= slot_bit;
            state_q <= S_SRB;
          end
        end
        S_SRB: begin
          issue(`SWM_OP_RD, 1'b1);
          if (fin) begin
            if (a_q && slot_bit) begin
              err_code_out <= `SWM_ERR_DATA;
              state_q <= S_FAIL;
            end else begin
              // Devices with the other value drop out
              dir_q <= (a_q != slot_bit) ? a_q : id_q[idx_q];
              state_q <= S_SRW;
            end
          end
        end
        S_SRW: begin
          issue(`SWM_OP_WR, dir_q);
          if (fin) begin
            rom_out[idx_q] <= dir_q;
            idx_q <= idx_q + 6'h01;
            state_q <= (idx_q == 6'h3F) ? S_ROMEND : S_SRA;
          end
        end
        S_ROMEND: begin
          if (rop_q == `SWM_ROP_READ) begin
            rom_out <= sh_q;
          end
          if (!wr_q) begin
            state_q <= S_DONE;
          end else begin
            // Command, address low, address high, data
            feed_q <= {data_q, addr_out[15:8], addr_out[7:0],
                       spd_q ? `SWM_CMD_WR_STAT_F : `SWM_CMD_WR_STAT};
            sh_q <= {32'h0, data_q, addr_out[15:8], addr_out[7:0],
                     spd_q ? `SWM_CMD_WR_STAT_F : `SWM_CMD_WR_STAT};
            crc_clr_q <= 1'b1;
            k_q <= 2'h0;
            n_q <= 7'd32;
            ret_q <= S_CALC;
            state_q <= S_TX;
          end
        end
        S_CALC: begin
          crc_en_q <= 1'b1;
          crc_byte_q <= feed_q[7:0];
          feed_q <= {8'h00, feed_q[31:8]};
          k_q <= k_q + 2'h1;
          if (k_q == 2'h3) begin
            n_q <= 7'd16;
            ret_q <= S_CRCCHK;
            state_q <= spd_q ? S_PROG : S_RX;
          end
        end
        S_CRCCHK: begin
          // Device returns the CRC inverted; top-bit forcing shows here
          if (~sh_q[63:48] == crc_val) begin
            crc_ok_out <= 1'b1;
            state_q <= S_PROG;
          end else begin
            crc_ok_out <= 1'b0;
            err_code_out <= `SWM_ERR_CRC;
            state_q <= S_FAIL;
          end
        end
        S_PROG: begin
          issue(`SWM_OP_PROG, 1'b1);
          if (fin) begin
            n_q <= 7'd8;
            ret_q <= S_VER;
            state_q <= S_RX;
          end
        end
        S_VER: begin
          verify_byte_out <= sh_q[63:56];
          if ((sh_q[63:56] & ~data_q) != 8'h00) begin
            err_code_out <= `SWM_ERR_DATA;
            state_q <= S_FAIL;
          end else begin
            addr_out <= addr_out + 16'h0001;
            state_q <= last_q ? S_DONE : S_NEXT;
          end
        end
        S_NEXT: begin
          byte_ready_out <= 1'b1;
          if (byte_valid_in && byte_ready_out) begin
            byte_ready_out <= 1'b0;
            data_q <= data_in;
            last_q <= last_in;
            crc_ld_q <= 1'b1;
            feed_q <= {24'h0, data_in};
            sh_q <= {56'h0, data_in};
            k_q <= 2'h3;
            n_q <= 7'd8;
            ret_q <= S_CALC;
            state_q <= S_TX;
          end
        end
        S_FAIL: begin
          issue(`SWM_OP_RST, 1'b0);
          if (fin) begin
            if (long_q) begin
              overdrive_flag_out <= 1'b0;
            end
            state_q <= S_DONE;
          end
        end
        S_DONE: begin
          done_out <= 1'b1;
          error_out <= (err_code_out != `SWM_ERR_NONE);
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- swm_monitor.sv ----
// Port checker for the single-wire bus master: line, program pulse, handshake.
// Assumes one clock domain and a synchronous active-high reset.
module swm_monitor #(
  parameter [19:0] RST_CYC  = 20'h2580,
  parameter [19:0] PROG_CYC = 20'h2580
) (
  input wire       clock_in,
  input wire       reset_in,
  input wire       cmd_valid_in,
  input wire       cmd_ready_out,
  input wire       long_reset_in,
  input wire       line_oe_n_out,
  input wire       prog_en_out,
  input wire       done_out,
  input wire       error_out,
  input wire [1:0] err_code_out,
  input wire       overdrive_flag_out
);
  logic [19:0] pcnt_q;
  logic [19:0] lcnt_q;
  logic        took_q;
  always @(posedge clock_in) begin
    if (reset_in) begin
      pcnt_q <= 20'h0;
      lcnt_q <= 20'h0;
      took_q <= 1'b0;
    end else begin
      pcnt_q <= prog_en_out ? pcnt_q + 20'h1 : 20'h0;
      lcnt_q <= line_oe_n_out ? 20'h0 : lcnt_q + 20'h1;
      if (cmd_valid_in && cmd_ready_out) took_q <= 1'b1;
      else if (line_oe_n_out && lcnt_q != 20'h0) took_q <= 1'b0;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  prog_safe_a: assert property (prog_en_out |-> line_oe_n_out)
    else $error("line pulled low during program pulse");
  prog_len_a: assert property (
    $fell(prog_en_out) |-> pcnt_q >= PROG_CYC)
    else $error("program pulse too short");
  idle_release_a: assert property (
    cmd_ready_out |-> line_oe_n_out && !prog_en_out)
    else $error("line not idle while ready");
  low_bound_a: assert property (lcnt_q <= RST_CYC + 20'h1)
    else $error("line held low too long");
  reset_first_a: assert property (
    $rose(line_oe_n_out) && took_q |-> lcnt_q >= 20'h577)
    else $error("transaction did not open with a reset pulse");
  start_reset_a: assert property (
    cmd_valid_in && cmd_ready_out |-> ##[1:6] !line_oe_n_out)
    else $error("no line activity after request");
  take_busy_a: assert property (
    cmd_valid_in && cmd_ready_out |=> !cmd_ready_out[*8])
    else $error("ready during transaction");
  done_ready_a: assert property (
    done_out |=> cmd_ready_out && !done_out)
    else $error("done not a single pulse before ready");
  od_exit_a: assert property (
    $fell(overdrive_flag_out) |-> long_reset_in)
    else $error("overdrive left without long reset");
  err_flag_a: assert property (
    done_out |-> error_out == (err_code_out != 2'h0))
    else $error("error flag disagrees with code");
  cover property ($fell(prog_en_out));
  cover property (done_out && error_out);
  cover property ($fell(overdrive_flag_out));
endmodule

bind swm_master swm_monitor #(.RST_CYC(RST_CYC), .PROG_CYC(PROG_CYC))
  mon (.*);

// ---- swm_regs.vh ----
// Constants for the single-wire bus master: commands, slot timing, codes.
// Assumes a 20 MHz system clock; times are in ns, counts in clock cycles.
`ifndef SWM_REGS_VH
`define SWM_REGS_VH

`define SWM_CLK_NS        50
// Least time rounds up to whole cycles
`define SWM_CYC(t)        (((t) + `SWM_CLK_NS - 1) / `SWM_CLK_NS)

// Regular speed timing, ns
`define SWM_REG_RSTL_NS   480000
`define SWM_REG_PSMP_NS   70000
`define SWM_REG_RREC_NS   410000
`define SWM_REG_SLOT_NS   70000
`define SWM_REG_W0L_NS    60000
`define SWM_REG_W1L_NS    6000
`define SWM_REG_RDL_NS    6000
`define SWM_REG_RDS_NS    13000
// Overdrive timing, ns
`define SWM_OD_RSTL_NS    70000
`define SWM_OD_PSMP_NS    8500
`define SWM_OD_RREC_NS    40000
`define SWM_OD_SLOT_NS    10000
`define SWM_OD_W0L_NS     8000
`define SWM_OD_W1L_NS     1000
`define SWM_OD_RDL_NS     1000
`define SWM_OD_RDS_NS     1500
// Program pulse and its recovery, ns
`define SWM_PROG_NS       480000
`define SWM_PREC_NS       10000

// Cycle counts
`define SWM_REG_RSTL_CYC  `SWM_CYC(`SWM_REG_RSTL_NS)
`define SWM_REG_PSMP_CYC  `SWM_CYC(`SWM_REG_PSMP_NS)
`define SWM_REG_RREC_CYC  `SWM_CYC(`SWM_REG_RREC_NS)
`define SWM_REG_SLOT_CYC  `SWM_CYC(`SWM_REG_SLOT_NS)
`define SWM_REG_W0L_CYC   `SWM_CYC(`SWM_REG_W0L_NS)
`define SWM_REG_W1L_CYC   `SWM_CYC(`SWM_REG_W1L_NS)
`define SWM_REG_RDL_CYC   `SWM_CYC(`SWM_REG_RDL_NS)
`define SWM_REG_RDS_CYC   `SWM_CYC(`SWM_REG_RDS_NS)
`define SWM_OD_RSTL_CYC   `SWM_CYC(`SWM_OD_RSTL_NS)
`define SWM_OD_PSMP_CYC   `SWM_CYC(`SWM_OD_PSMP_NS)
`define SWM_OD_RREC_CYC   `SWM_CYC(`SWM_OD_RREC_NS)
`define SWM_OD_SLOT_CYC   `SWM_CYC(`SWM_OD_SLOT_NS)
`define SWM_OD_W0L_CYC    `SWM_CYC(`SWM_OD_W0L_NS)
`define SWM_OD_W1L_CYC    `SWM_CYC(`SWM_OD_W1L_NS)
`define SWM_OD_RDL_CYC    `SWM_CYC(`SWM_OD_RDL_NS)
`define SWM_OD_RDS_CYC    `SWM_CYC(`SWM_OD_RDS_NS)
`define SWM_PROG_CYC      `SWM_CYC(`SWM_PROG_NS)
`define SWM_PREC_CYC      `SWM_CYC(`SWM_PREC_NS)

// Slot operations
`define SWM_OP_RST        2'h0
`define SWM_OP_WR         2'h1
`define SWM_OP_RD         2'h2
`define SWM_OP_PROG       2'h3

// Identity-phase selections on rom_op_in
`define SWM_ROP_SKIP      3'h0
`define SWM_ROP_MATCH     3'h1
`define SWM_ROP_READ      3'h2
`define SWM_ROP_SEARCH    3'h3
`define SWM_ROP_OD_SKIP   3'h4
`define SWM_ROP_OD_MATCH  3'h5

// Command codes on the line
`define SWM_CMD_READ_ID   8'h33
`define SWM_CMD_MATCH_ID  8'h55
`define SWM_CMD_SKIP_ID   8'hCC
`define SWM_CMD_SEARCH_ID 8'hF0
`define SWM_CMD_OD_SKIP   8'h3C
`define SWM_CMD_OD_MATCH  8'h69
`define SWM_CMD_WR_STAT   8'h55
`define SWM_CMD_WR_STAT_F 8'hF5

// CRC16 reflected polynomial
`define SWM_CRC_POLY      16'hA001

// Error codes
`define SWM_ERR_NONE      2'h0
`define SWM_ERR_NOPRES    2'h1
`define SWM_ERR_CRC       2'h2
`define SWM_ERR_DATA      2'h3

`endif

// ---- swm_slot.v ----
// Time-slot engine: reset/presence, write bit, read bit, program pulse.
// Assumes one open-drain line with pull-up; line_in is asynchronous.
`include "swm_regs.vh"

module swm_slot #(
  parameter [19:0] RST_CYC  = `SWM_REG_RSTL_CYC,
  parameter [19:0] RREC_CYC = `SWM_REG_RREC_CYC,
  parameter [19:0] PROG_CYC = `SWM_PROG_CYC
) (
  input  wire       clock_in,
  input  wire       reset_in,
  input  wire       go_in,
  input  wire [1:0] op_in,
  input  wire       bit_in,
  input  wire       od_in,
  input  wire       line_in,
  output reg        done_out,
  output reg        bit_out,
  output reg        line_oe_n_out,
  output reg        prog_en_out
);

  localparam [19:0] REG_PSMP = `SWM_REG_PSMP_CYC;
  localparam [19:0] REG_SLOT = `SWM_REG_SLOT_CYC;
  localparam [19:0] REG_W0L  = `SWM_REG_W0L_CYC;
  localparam [19:0] REG_W1L  = `SWM_REG_W1L_CYC;
  localparam [19:0] REG_RDL  = `SWM_REG_RDL_CYC;
  localparam [19:0] REG_RDS  = `SWM_REG_RDS_CYC;
  localparam [19:0] OD_RSTL  = `SWM_OD_RSTL_CYC;
  localparam [19:0] OD_PSMP  = `SWM_OD_PSMP_CYC;
  localparam [19:0] OD_RREC  = `SWM_OD_RREC_CYC;
  localparam [19:0] OD_SLOT  = `SWM_OD_SLOT_CYC;
  localparam [19:0] OD_W0L   = `SWM_OD_W0L_CYC;
  localparam [19:0] OD_W1L   = `SWM_OD_W1L_CYC;
  localparam [19:0] OD_RDL   = `SWM_OD_RDL_CYC;
  localparam [19:0] OD_RDS   = `SWM_OD_RDS_CYC;
  localparam [19:0] PREC     = `SWM_PREC_CYC;

  reg        line_m_q;
  reg        line_s_q;
  reg        busy_q;
  reg [1:0]  op_q;
  reg        b_q;
  reg        od_q;
  reg [19:0] cnt_q;
  reg [19:0] low;
  reg [19:0] smp;
  reg [19:0] tot;

  // Phase lengths of the current slot, picked by speed
  always @* begin
    low = 20'h00000;
    smp = 20'hFFFFF;
    tot = 20'h00001;
    case (op_q)
      `SWM_OP_RST: begin
        low = od_q ? OD_RSTL : RST_CYC;
        smp = low + (od_q ? OD_PSMP : REG_PSMP);
        tot = low + (od_q ? OD_RREC : RREC_CYC);
      end
      `SWM_OP_WR: begin
        if (b_q) begin
          low = od_q ? OD_W1L : REG_W1L;
        end else begin
          low = od_q ? OD_W0L : REG_W0L;
        end
        tot = od_q ? OD_SLOT : REG_SLOT;
      end
      `SWM_OP_RD: begin
        low = od_q ? OD_RDL : REG_RDL;
        smp = od_q ? OD_RDS : REG_RDS;
        tot = od_q ? OD_SLOT : REG_SLOT;
      end
      default: begin
        tot = PROG_CYC + PREC;
      end
    endcase
  end

  always @(posedge clock_in) begin
    if (reset_in) begin
      line_m_q      <= 1'b1;
      line_s_q      <= 1'b1;
      busy_q        <= 1'b0;
      op_q          <= `SWM_OP_RST;
      b_q           <= 1'b0;
      od_q          <= 1'b0;
      cnt_q         <= 20'h00000;
      done_out      <= 1'b0;
      bit_out       <= 1'b0;
      line_oe_n_out <= 1'b1;
      prog_en_out   <= 1'b0;
    end else begin
      line_m_q <= line_in;
      line_s_q <= line_m_q;
      done_out <= 1'b0;
      if (!busy_q && go_in) begin
        busy_q <= 1'b1;
        op_q   <= op_in;
        b_q    <= bit_in;
        od_q   <= od_in;
        cnt_q  <= 20'h00000;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 20'h00001;
        if (cnt_q == smp) begin
          bit_out <= (op_q == `SWM_OP_RST) ? ~line_s_q : line_s_q;
        end
        if (cnt_q == tot - 20'h00001) begin
          busy_q   <= 1'b0;
          done_out <= 1'b1;
        end
      end
      // Only low phases pull the line; idle high between slots
      line_oe_n_out <= ~(busy_q && (cnt_q < low));
      prog_en_out   <= busy_q && (op_q == `SWM_OP_PROG) &&
                       (cnt_q < PROG_CYC);
    end
  end

endmodule

// ---- test_single_wire_rom_and_status_write.sv ----
// Bench for the single-wire bus master against a behavioural slave.
// Assumes a pull-up on the line and shortened reset and program counts.
module test_single_wire_rom_and_status_write;
  timeunit 1ns;
  timeprecision 100ps;
  // Arbitrary identity value
  localparam logic [63:0] ID = 64'h9C3A5E710B2D4E88;
  typedef struct {
    logic [1:0]  e;
    logic        o;
    logic [15:0] a;
    logic [7:0]  v;
    logic [63:0] r;
    logic [1:0]  m;
    logic        c;
  } swm_exp_t;
  logic        clock_in = 1'b0, reset_in = 1'b1, cmd_valid_in = 1'b0;
  logic        long_reset_in = 1'b0, write_in = 1'b0, speed_write_in = 1'b0;
  logic        last_in = 1'b0, byte_valid_in = 1'b0, pull_n;
  logic [2:0]  rom_op_in = 3'h0;
  logic [63:0] rom_id_in = ID;
  logic [15:0] addr_in = 16'h0;
  logic [7:0]  data_in = 8'h0;
  logic        cmd_ready_out, byte_ready_out, line_oe_n_out, prog_en_out;
  logic        done_out, error_out, presence_out, crc_ok_out;
  logic        overdrive_flag_out;
  logic [1:0]  err_code_out;
  logic [7:0]  verify_byte_out;
  logic [15:0] addr_out;
  logic [63:0] rom_out;
  wire         line_in = line_oe_n_out & pull_n;
  int          failures = 0, comparisons = 0, seed = 32'h2C57D26D;
  swm_exp_t    q[$];
  swm_exp_t    x;
  swm_master #(.RST_CYC(20'h7D0), .RREC_CYC(20'h640), .PROG_CYC(20'hC8))
    dut (.*);
  swm_dev_model #(.ID(ID))
    dev (.line_in(line_in), .prog_in(prog_en_out), .pull_n_out(pull_n));
  always #25 clock_in = ~clock_in;
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic ck(string n, logic [63:0] e, logic [63:0] s);
    comparisons++;
    if (e !== s) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic ws(input int w);
    for (int i = 0; i < 60000; i++) begin
      @(posedge clock_in);
      if (w == 0 ? cmd_ready_out === 1'b1 : w == 1 ?
          byte_ready_out === 1'b1 : done_out === 1'b1) return;
    end
    failures++;
    test_done();
  endtask
  task automatic tr(input logic [2:0] op, input logic lr, wr, sp,
                    input logic [15:0] a, input logic n2,
                    input logic [1:0] e, input logic o, input logic [1:0] m);
    swm_exp_t y;
    @(posedge clock_in);
    #2;
    {rom_op_in, long_reset_in, write_in, speed_write_in} = {op, lr, wr, sp};
    addr_in = a;
    data_in = $random(seed);
    last_in = !n2;
    y = '{e, o, a + 16'h1 + n2, data_in, ID, m, wr && !sp && e == 2'h0};
    cmd_valid_in = 1'b1;
    ws(0);
    #2;
    cmd_valid_in = 1'b0;
    if (n2) begin
      ws(1);
      #2;
      data_in = $random(seed);
      y.v = data_in;
      last_in = 1'b1;
      byte_valid_in = 1'b1;
      ws(1);
      #2;
      byte_valid_in = 1'b0;
    end
    q.push_back(y);
    ws(2);
  endtask
  always @(posedge clock_in) if (done_out === 1'b1) begin
    x = q.pop_front();
    ck("presence_out", 1'b1, presence_out);
    ck("err_code_out", x.e, err_code_out);
    ck("error_out", x.e != 2'h0, error_out);
    ck("crc_ok_out", x.c, crc_ok_out);
    ck("overdrive_flag_out", x.o, overdrive_flag_out);
    if (x.m[0]) ck("rom_out", x.r, rom_out);
    if (x.m[1]) ck("addr_out", x.a, addr_out);
    if (x.m[1]) ck("verify_byte_out", x.v, verify_byte_out);
  end
  initial begin
    repeat (12) @(posedge clock_in);
    #2;
    reset_in = 1'b0;
    tr(3'h4, 0, 0, 0, 16'h0, 0, 2'h0, 1, 2'h0);
    tr(3'h3, 0, 0, 0, 16'h0, 0, 2'h0, 1, 2'h1);
    tr(3'h0, 0, 1, 1, $random(seed) & 16'h00FE, 1, 2'h0, 1, 2'h2);
    tr(3'h5, 0, 1, 0, 16'h0100 | $random(seed) & 16'h00FE, 0, 2'h0, 1,
       2'h2);
    tr(3'h2, 0, 1, 0, 16'hE000 | $random(seed) & 16'h00FF, 0, 2'h2, 1,
       2'h1);
    tr(3'h0, 1, 0, 0, 16'h0, 0, 2'h0, 0, 2'h0);
    test_done();
  end
endmodule
